// ### include/dual_rail_cfg.svh
// Constants for the dual-rail level register bank.
`ifndef DUAL_RAIL_CFG_SVH
`define DUAL_RAIL_CFG_SVH

`define SLAVE_ADDR        7'h3e
`define OFS_POS_LEVEL     8'h00
`define OFS_NEG_LEVEL     8'h01
`define OFS_MODE_CTRL     8'h03
`define CODE_W            5
`define CODE_DEFAULT_LOW  5'h0a
`define CODE_DEFAULT_HIGH 5'h0e
`define MODE_RESET        8'h03
`define BYTE_BITS         4'h8
`define CLOCK_KHZ         20000
`define SCL_STD_MAX_KHZ   100
`define SCL_FAST_MAX_KHZ  400
`define SYS_PER_SCL_CYC   (`CLOCK_KHZ / `SCL_FAST_MAX_KHZ)

`endif

// ### include/dual_rail_pkg.sv
// Types shared by the dual-rail level register bank.
package dual_rail_pkg;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ADDR,
		PH_SUB,
		PH_DATA
	} phase_e;

	typedef struct packed {
		logic       en;
		logic [7:0] ofs;
		logic [7:0] data;
	} reg_wr_s;

	typedef struct packed {
		logic scl;
		logic sda;
		logic en1;
		logic en2;
		logic tog;
	} pin_sync_s;

endpackage

// ### design/i2c_bit_capture.sv
// Serial-clock domain capture of each data bit on the rising clock edge.
`timescale 1ns/10ps
module i2c_bit_capture (
	input  wire logic scl_clock,
	input  wire logic arst_n,
	input  wire logic sda_i,
	output logic      bit_q,
	output logic      toggle_q
);

	// The bit stays put until the next rising edge, which is many system clocks away.
	always_ff @(posedge scl_clock or negedge arst_n) begin
		if (!arst_n) begin
			bit_q    <= 1'b0;
			toggle_q <= 1'b0;
		end else begin
			bit_q    <= sda_i;
			toggle_q <= ~toggle_q;
		end
	end

endmodule

// ### design/dual_rail_voltage_i2c_regs.sv
// Write-only serial register bank holding the two rail level codes and the mode byte.
`timescale 1ns/10ps
`include "dual_rail_cfg.svh"

// Overview of operation
// - Answer slave address 0111110 only with the write direction bit.
// - Offset 0x00 holds the positive rail code in bits 4 to 0.
// - Offset 0x01 holds the negative rail code in bits 4 to 0.
// - Code n selects 4.0 V plus n times 0.1 V; code 0 unused.
// - Both level codes reset to the variant default, 10 or 14.
// - In standby the interface neither acknowledges nor accepts writes.
// - Serial clock runs up to 100 kHz or 400 kHz.
// - Acknowledge by pulling data low in clock nine, release at its fall.
// - Successive data bytes advance the register pointer by one.
module dual_rail_voltage_i2c_regs
	import dual_rail_pkg::*;
#(
	parameter bit HIGH_VARIANT = 1'b0
) (
	input  wire logic                 clock,
	input  wire logic                 arst_n,
	input  wire logic                 scl_clock,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_n,
	input  wire logic                 first_rail_enable,
	input  wire logic                 second_rail_enable,
	output logic [`CODE_W-1:0]        positive_rail_code,
	output logic [`CODE_W-1:0]        negative_rail_code,
	output logic [7:0]                mode_control
);

	localparam logic [`CODE_W-1:0] DEFAULT_CODE = HIGH_VARIANT ? `CODE_DEFAULT_HIGH : `CODE_DEFAULT_LOW;
	// Synchronisers start at the idle pin levels, so no false edge or enable follows reset.
	localparam pin_sync_s PIN_IDLE = '{scl: 1'b1, sda: 1'b1, en1: 1'b0, en2: 1'b0, tog: 1'b0};

	logic      link_bit;
	logic      link_toggle;
	pin_sync_s s1_q;
	pin_sync_s s2_q;
	pin_sync_s s3_q;
	pin_sync_s pins;

	phase_e     phase_q;
	phase_e     phase_d;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] ptr_q;
	logic [7:0] ptr_d;
	logic       ack_q;
	logic       ack_d;
	reg_wr_s    wr;

	logic       start_seen;
	logic       stop_seen;
	logic       scl_fall;
	logic       bit_rx;
	logic       active;
	logic       byte_done;
	logic       addr_match;
	logic       hit_pos;
	logic       hit_neg;
	logic       hit_mode;

	// Data bits are taken on the serial clock itself; everything else is oversampled.
	i2c_bit_capture u_capture (
		.scl_clock (scl_clock),
		.arst_n    (arst_n),
		.sda_i     (sda_i),
		.bit_q     (link_bit),
		.toggle_q  (link_toggle)
	);

	assign pins = '{scl: scl_clock, sda: sda_i, en1: first_rail_enable,
		en2: second_rail_enable, tog: link_toggle};

	// Two flip-flops per pin before use, a third stage only for edge detection.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// At 20 MHz even a 400 kHz serial clock leaves about fifty samples per period.
	assign start_seen = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
	assign stop_seen  = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;
	assign scl_fall   = s3_q.scl & ~s2_q.scl;
	// The captured bit is stable long before its toggle is seen here.
	assign bit_rx     = s2_q.tog ^ s3_q.tog;
	assign active     = s2_q.en1 | s2_q.en2;
	assign byte_done  = scl_fall & (bit_cnt_q == `BYTE_BITS) & ~ack_q;

	assign addr_match = (shift_q[7:1] == `SLAVE_ADDR) & ~shift_q[0];
	assign hit_pos    = wr.ofs == `OFS_POS_LEVEL;
	assign hit_neg    = wr.ofs == `OFS_NEG_LEVEL;
	assign hit_mode   = wr.ofs == `OFS_MODE_CTRL;

	assign wr = '{en: byte_done & (phase_q == PH_DATA), ofs: ptr_q, data: shift_q};

	always_comb begin
		phase_d   = phase_q;
		bit_cnt_d = bit_cnt_q;
		shift_d   = shift_q;
		ptr_d     = ptr_q;
		ack_d     = ack_q;
		if (!active || stop_seen) begin
			phase_d   = PH_IDLE;
			bit_cnt_d = 4'h0;
			ack_d     = 1'b0;
		end else if (start_seen) begin
			phase_d   = PH_ADDR;
			bit_cnt_d = 4'h0;
			ack_d     = 1'b0;
		end else if (phase_q != PH_IDLE) begin
			if (bit_rx) begin
				if (bit_cnt_q == `BYTE_BITS) begin
					bit_cnt_d = 4'h0;
				end else begin
					shift_d   = {shift_q[6:0], link_bit};
					bit_cnt_d = bit_cnt_q + 4'h1;
				end
			end
			if (scl_fall && ack_q) begin
				ack_d = 1'b0;
			end else if (byte_done) begin
				case (phase_q)
					PH_ADDR: begin
						if (addr_match) begin
							phase_d = PH_SUB;
							ack_d   = 1'b1;
						end else begin
							phase_d   = PH_IDLE;
							bit_cnt_d = 4'h0;
						end
					end
					PH_SUB: begin
						ptr_d   = shift_q;
						phase_d = PH_DATA;
						ack_d   = 1'b1;
					end
					PH_DATA: begin
						ptr_d = ptr_q + 8'h01;
						ack_d = 1'b1;
					end
					default: begin
						phase_d = PH_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_q   <= PH_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
			ptr_q     <= 8'h00;
			ack_q     <= 1'b0;
		end else begin
			phase_q   <= phase_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q   <= shift_d;
			ptr_q     <= ptr_d;
			ack_q     <= ack_d;
		end
	end

	// The pad only ever pulls low, so the data output is a constant zero from a flip-flop.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sda_o    <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			sda_o    <= 1'b0;
			sda_oe_n <= ~ack_d;
		end
	end

	// The stored codes map to 4.0 V plus code times 0.1 V in the converter.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			positive_rail_code <= DEFAULT_CODE;
			negative_rail_code <= DEFAULT_CODE;
			mode_control       <= `MODE_RESET;
		end else if (wr.en) begin
			// Out-of-range codes are kept as written; the converter decides what they mean.
			if (hit_pos) begin
				positive_rail_code <= wr.data[`CODE_W-1:0];
			end
			if (hit_neg) begin
				negative_rail_code <= wr.data[`CODE_W-1:0];
			end
			// Mode bits are stored as written; keeping bits 1 and 0 set is up to the master.
			if (hit_mode) begin
				mode_control <= wr.data;
			end
		end
	end

endmodule

// ### dv/dual_rail_voltage_i2c_regs_assertions.sv
// Pin-level checks of the dual-rail level register bank.
`timescale 1ns/10ps
`include "dual_rail_cfg.svh"
module dual_rail_voltage_i2c_regs_assertions #(
	parameter bit HIGH_VARIANT = 1'b0
) (
	input wire logic	clock,
	input wire logic	arst_n,
	input wire logic	scl_clock,
	input wire logic	sda_o,
	input wire logic	sda_oe_n,
	input wire logic	first_rail_enable,
	input wire logic	second_rail_enable,
	input wire logic [4:0]	positive_rail_code,
	input wire logic [4:0]	negative_rail_code,
	input wire logic [7:0]	mode_control
);
	wire [4:0]	dflt = HIGH_VARIANT ? `CODE_DEFAULT_HIGH : `CODE_DEFAULT_LOW;
	wire		idle = !first_rail_enable && !second_rail_enable;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	chk_reset_value: assert property ($rose(arst_n) |-> positive_rail_code == dflt
		&& negative_rail_code == dflt && mode_control == `MODE_RESET) else $error("reset value");
	chk_ack_low: assert property (!sda_oe_n |-> !sda_o) else $error("ack level");
	chk_ack_width: assert property ($fell(sda_oe_n) |-> !scl_clock ##1 !sda_oe_n [*8]) else $error("width");
	chk_ack_release: assert property ($fell(scl_clock) && !sda_oe_n |-> ##[1:6] sda_oe_n) else $error("stuck");
	// Moving the data line while the serial clock is high would look like a start or stop.
	chk_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_clock) else $error("ack moved, clock high");
	chk_standby_mute: assert property (idle [*5] |-> sda_oe_n) else $error("standby ack");
	chk_standby_hold: assert property (idle [*5] |=> $stable(positive_rail_code)
		&& $stable(negative_rail_code) && $stable(mode_control)) else $error("standby write");
	chk_pos_acked: assert property ($changed(positive_rail_code) |-> ##[0:2] !sda_oe_n) else $error("pos");
	chk_neg_acked: assert property ($changed(negative_rail_code) |-> ##[0:2] !sda_oe_n) else $error("neg");
endmodule

// ### dv/i2c_master_model.sv
// Serial bus master that writes the register bank.
`timescale 1ns/10ps
module i2c_master_model (
	output logic		scl,
	output logic		sda_drv,
	input wire logic	sda
);
	initial {scl, sda_drv} = 2'b11;
	task start;
		sda_drv = 0;
		#700 scl = 0;
	endtask
	// The ninth bit is sent as one so the line is free for the acknowledge.
	task wbyte(input logic [8:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			// A 2.5 us bit period keeps the clock at the 400 kHz ceiling.
			#300 sda_drv = b[i];
			#1500 scl = 1;
			#700 ack = !sda;
			scl = 0;
		end
	endtask
	task stop;
		#300 sda_drv = 0;
		#1000 scl = 1;
		#700 sda_drv = 1;
		#1300;
	endtask
endmodule

// ### dv/tb_dual_rail_voltage_i2c_regs.sv
// Self-checking bench for the dual-rail level register bank.
`timescale 1ns/10ps
`include "dual_rail_cfg.svh"
module tb_dual_rail_voltage_i2c_regs;
	logic		clock = 0, arst_n = 0, en1 = 0, en2 = 0, scl, sda_drv, sda_o, sda_oe_n, ack;
	logic [4:0]	pos, neg;
	logic [7:0]	mode, ep = {3'h0, `CODE_DEFAULT_HIGH}, en = {3'h0, `CODE_DEFAULT_HIGH}, em = `MODE_RESET, rnd = 8'h39;
	int		n_errors = 0, cmp_count = 0;
	wire		sda = sda_drv & (sda_oe_n | sda_o);
	always #25 clock = ~clock;
	i2c_master_model i_mst (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	dual_rail_voltage_i2c_regs #(.HIGH_VARIANT(1'b1)) i_dut (.clock(clock), .arst_n(arst_n), .scl_clock(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .first_rail_enable(en1),
		.second_rail_enable(en2), .positive_rail_code(pos), .negative_rail_code(neg), .mode_control(mode));
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Level codes stay within 1 to 17, since the master never sends an unused code.
	function logic [7:0] lvl(input logic [7:0] s);
		return {s[7:5], s[4:0] % 5'd17 + 5'd1};
	endfunction
	task tally_and_finish;
		if (n_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] q[$], input logic ok);
		logic [7:0] p;
		p = q[0];
		i_mst.start();
		i_mst.wbyte({a, 1'b1}, ack);
		chk(ack, ok);
		// Refused transfers still clock their bytes, which must be neither acknowledged nor stored.
		for (int i = 0; i < q.size(); i++) begin
			i_mst.wbyte({q[i], 1'b1}, ack);
			chk(ack, ok);
			if (ok && i > 0 && p == 0) ep = q[i] & 8'h1f;
			if (ok && i > 0 && p == 1) en = q[i] & 8'h1f;
			if (ok && i > 0 && p == 3) em = q[i];
			if (i > 0) p++;
		end
		i_mst.stop();
		chk(pos, ep);
		chk(neg, en);
		chk(mode, em);
	endtask
	initial begin
		repeat (6) @(negedge clock);
		arst_n <= 1;
		en1 <= 1;
		repeat (4) @(negedge clock);
		wr(8'h7e, {8'h00}, 0);
		wr(8'h70, {8'h00}, 0);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			wr(8'h7c, {rnd & 8'h01, lvl(rnd), lvl(~rnd), rnd | 8'h03, rnd | 8'h03}, 1);
		end
		@(negedge clock) en1 <= 0;
		repeat (5) @(negedge clock);
		wr(8'h7c, {8'h00, 8'h11}, 0);
		@(negedge clock) en2 <= 1;
		repeat (4) @(negedge clock);
		wr(8'h7c, {8'h00, 8'h0a, 8'h0a}, 1);
		tally_and_finish;
	end
	initial begin
		#2000000;
		n_errors++;
		tally_and_finish;
	end
endmodule
bind dual_rail_voltage_i2c_regs dual_rail_voltage_i2c_regs_assertions #(.HIGH_VARIANT(HIGH_VARIANT)) i_chk (
	.clock              (clock),
	.arst_n             (arst_n),
	.scl_clock          (scl_clock),
	.sda_o              (sda_o),
	.sda_oe_n           (sda_oe_n),
	.first_rail_enable  (first_rail_enable),
	.second_rail_enable (second_rail_enable),
	.positive_rail_code (positive_rail_code),
	.negative_rail_code (negative_rail_code),
	.mode_control       (mode_control)
);
